// >>> timer_pkg.sv
// Shared constants and types for the capture/compare timer.
// Assumes a single 100 MHz clock and a synchronous active-high reset in every user.
package timer_pkg;

    // Widths of the prescaler, the two counter variants, the dead-time counter, the channel mode and the hall inputs.
    localparam int PSC_W        = 16;
    localparam int WIDE_CNT_W   = 32;
    localparam int NARROW_CNT_W = 16;
    localparam int DT_W         = 8;
    localparam int MODE_W       = 3;
    localparam int HALL_W       = 3;

    // Channel counts of the richest variant.
    localparam int DEFAULT_CH   = 4;
    localparam int DEFAULT_COMP = 3;

    // Reset value of the prescaler count.
    localparam logic [PSC_W-1:0] PSC_RESET = 16'h0000;

    // Counting direction modes.
    typedef enum logic [1:0] {
        CNT_UP     = 2'b00,
        CNT_DOWN   = 2'b01,
        CNT_CENTER = 2'b10
    } cnt_mode_t;

    // Ways in which the counter is driven or controlled from outside.
    typedef enum logic [2:0] {
        SLV_FREE      = 3'b000,
        SLV_ENCODER   = 3'b001,
        SLV_GATED     = 3'b010,
        SLV_TRIGGER   = 3'b011,
        SLV_EXT_CLOCK = 3'b100
    } slave_mode_t;

    // Per-channel function.
    typedef enum logic [2:0] {
        CH_OFF       = 3'b000,
        CH_CAPTURE   = 3'b001,
        CH_COMPARE   = 3'b010,
        CH_PWM       = 3'b011,
        CH_ONE_PULSE = 3'b100
    } ch_mode_t;

endpackage

// >>> capture_compare_channel.sv
// One capture/compare channel with an optional complementary pair and dead time.
// Assumes the counter value and step strobe come from the timer core in the same clock.
`timescale 1ns/100ps
module capture_compare_channel #(
    parameter int CNT_W    = 16,
    parameter bit HAS_COMP = 1'b0
) (
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    input  wire logic                      cnt_step,
    input  wire logic [CNT_W-1:0]          cnt,
    input  wire logic [CNT_W-1:0]          cmp,
    input  wire logic [2:0]                mode,
    input  wire logic                      cap_in,
    input  wire logic [timer_pkg::DT_W-1:0] dead_time,
    output logic                           out_p,
    output logic                           out_n,
    output logic [CNT_W-1:0]               cap_val,
    output logic                           cap_event
);

    logic                      ref_lvl;
    logic                      ref_d;
    logic                      cap_d;
    logic [timer_pkg::DT_W-1:0] dt_cnt;
    logic                      settled;

    // Reference waveform; in PWM mode compare above the reload gives a constant high, zero a constant low.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ref_lvl <= 1'b0;
        end else begin
            case (mode)
                timer_pkg::CH_PWM:       ref_lvl <= (cnt < cmp); // R4 R5
                timer_pkg::CH_ONE_PULSE: ref_lvl <= (cnt >= cmp) && (cmp != '0); // R3
                timer_pkg::CH_COMPARE: begin
                    if (cnt_step && (cnt == cmp)) begin
                        ref_lvl <= ~ref_lvl; // R3
                    end
                end
                default:                 ref_lvl <= 1'b0;
            endcase
        end
    end

    // Dead-time timer restarts on every reference edge so neither side turns on early.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ref_d  <= 1'b0;
            dt_cnt <= '0;
        end else begin
            ref_d <= ref_lvl;
            if (ref_lvl != ref_d) begin
                dt_cnt <= '0;
            end else if (dt_cnt != dead_time) begin
                dt_cnt <= dt_cnt + 1'b1;
            end
        end
    end

    assign settled = (ref_lvl == ref_d) && (dt_cnt == dead_time);

    // Output pair; without a complementary pin the main output follows the reference directly.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_p <= 1'b0;
            out_n <= 1'b0;
        end else if (HAS_COMP) begin
            out_p <= ref_lvl && settled; // R6 R8
            out_n <= !ref_lvl && settled && (mode != timer_pkg::CH_OFF); // R6 R8
        end else begin
            out_p <= ref_lvl;
            out_n <= 1'b0;
        end
    end

    // Rising edge of the capture input latches the counter.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cap_d     <= 1'b0;
            cap_val   <= '0;
            cap_event <= 1'b0;
        end else begin
            cap_d     <= cap_in;
            cap_event <= 1'b0;
            if ((mode == timer_pkg::CH_CAPTURE) && cap_in && !cap_d) begin
                cap_val   <= cnt; // R3
                cap_event <= 1'b1;
            end
        end
    end

    chk_pair_no_overlap: assert property (@(posedge clock) disable iff (sys_rst) // R6
        !(out_p && out_n)) else $error("Both outputs of the pair are high.");

    chk_dead_gap: assert property (@(posedge clock) disable iff (sys_rst) // R6
        (HAS_COMP && dead_time != '0 && $fell(out_p)) |=> !out_n)
        else $error("Complement rose without dead time.");

    chk_pwm_level: assert property (@(posedge clock) disable iff (sys_rst) // R5
        (!$past(sys_rst) && mode == timer_pkg::CH_PWM && $past(mode) == timer_pkg::CH_PWM)
        |-> ref_lvl == ($past(cnt) < $past(cmp))) else $error("PWM level does not follow compare.");

    chk_capture_value: assert property (@(posedge clock) disable iff (sys_rst) // R3
        cap_event |-> cap_val == $past(cnt)) else $error("Captured value is not the counter.");

    cov_capture: cover property (@(posedge clock) disable iff (sys_rst) cap_event);
    cov_dead_time: cover property (@(posedge clock) disable iff (sys_rst)
        HAS_COMP && $rose(out_n) && dead_time != '0);

endmodule

// >>> multi_channel_pwm_capture_timer.sv
// Auto-reload timer core with prescaler, slave control, encoder and hall inputs, and channels.
// Assumes all pins are synchronous to clock; configuration inputs are held stable by the owner.
//
// Behaviour
// R1 - Counter is 32 bits wide or 16 bits, always behind a 16-bit prescaler; encoder steps bypass the prescaler.
// R2 - Four-channel variants count up, down or up/down; single-channel ones only up.
// R3 - Each channel selects capture, compare, PWM or one-pulse output.
// R4 - PWM works with both edge-aligned and center-aligned counting.
// R5 - PWM duty covers zero to one hundred percent, constant levels included.
// R6 - Three complementary pairs with programmable dead time between the two sides.
// R7 - Advanced variant works as three-phase PWM on six lines.
// R8 - Single-channel complementary variants give one pair with dead time and DMA.
// R9 - Smallest variant has one channel and raises no DMA requests.
// R10 - Four-channel general timers raise their own DMA requests.
// R11 - Quadrature encoder inputs can drive the counter.
// R12 - One to three hall sensor inputs are accepted.
// R13 - Timers start, gate or clock one another over the link.
// R14 - Counter freezes while the processor is halted for debug, if enabled.
// R15 - Timer works as a plain time base with no channel active.
// R16 - Prescaler divides by its value plus one.
// R17 - Reaching reload going up or zero going down reloads and flags update.
`timescale 1ns/100ps
module multi_channel_pwm_capture_timer #(
    parameter int CNT_W    = timer_pkg::NARROW_CNT_W,
    parameter int NUM_CH   = timer_pkg::DEFAULT_CH,
    parameter int NUM_COMP = timer_pkg::DEFAULT_COMP,
    parameter bit UP_ONLY  = 1'b0,
    parameter bit HAS_DMA  = 1'b1
) (
    input  wire logic                          clock,
    input  wire logic                          sys_rst,
    input  wire logic                          enable,
    input  wire logic                          one_pulse,
    input  wire logic                          dbg_halt,
    input  wire logic                          dbg_freeze,
    input  wire logic [timer_pkg::PSC_W-1:0]   psc,
    input  wire logic [CNT_W-1:0]              arr,
    input  wire timer_pkg::cnt_mode_t          cnt_mode,
    input  wire timer_pkg::slave_mode_t        slave_mode,
    input  wire logic                          link_trig_in,
    input  wire logic                          enc_a,
    input  wire logic                          enc_b,
    input  wire logic [timer_pkg::HALL_W-1:0]  hall,
    input  wire logic                          hall_en,
    input  wire logic [NUM_CH*3-1:0]           ch_mode,
    input  wire logic [NUM_CH*CNT_W-1:0]       ch_cmp,
    input  wire logic [NUM_CH-1:0]             ch_in,
    input  wire logic [timer_pkg::DT_W-1:0]    dead_time,
    input  wire logic                          dma_en,
    input  wire logic                          update_clr,
    output logic [NUM_CH-1:0]                  ch_out,
    output logic [NUM_CH-1:0]                  ch_out_n,
    output logic [NUM_CH*CNT_W-1:0]            cap_val,
    output logic [NUM_CH-1:0]                  cap_flag,
    output logic [CNT_W-1:0]                   count,
    output logic                               count_down,
    output logic                               update_flag,
    output logic                               dma_req,
    output logic                               link_trig_out
);

    logic [timer_pkg::PSC_W-1:0] psc_cnt;
    logic [CNT_W-1:0]            cnt;
    logic                        dir_down;
    logic                        run;
    logic                        en_d;
    logic                        link_d;
    logic                        enc_a_d;
    logic                        enc_b_d;
    logic [timer_pkg::HALL_W-1:0] hall_d;
    logic                        ext_edge;
    logic                        active;
    logic                        clk_src;
    logic                        psc_tick;
    logic                        enc_step;
    logic                        enc_dn;
    logic                        start;
    logic                        hall_change;
    logic [CNT_W-1:0]            next_cnt;
    logic                        next_dir;
    logic                        wrap;
    logic                        step;
    timer_pkg::cnt_mode_t        eff_mode;

    // Edge detectors for link, encoder and hall pins.
    // Reset loads the present pin levels, so a pin resting high gives no false edge after reset.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_d    <= 1'b0;
            link_d  <= link_trig_in;
            enc_a_d <= enc_a;
            enc_b_d <= enc_b;
            hall_d  <= hall;
        end else begin
            en_d    <= enable;
            link_d  <= link_trig_in;
            enc_a_d <= enc_a;
            enc_b_d <= enc_b;
            hall_d  <= hall;
        end
    end

    // Counting qualifiers; the debug freeze and the gate simply withhold every step.
    assign ext_edge = link_trig_in && !link_d;
    assign active = run && !(dbg_halt && dbg_freeze) // R14
                    && ((slave_mode != timer_pkg::SLV_GATED) || link_trig_in); // R13
    assign clk_src  = (slave_mode == timer_pkg::SLV_EXT_CLOCK) ? ext_edge : 1'b1; // R13
    assign psc_tick = active && clk_src && (psc_cnt == psc)
                      && (slave_mode != timer_pkg::SLV_ENCODER); // R16
    assign enc_step = active && (slave_mode == timer_pkg::SLV_ENCODER)
                      && ((enc_a ^ enc_a_d) || (enc_b ^ enc_b_d)); // R11
    assign enc_dn   = !(enc_a_d ^ enc_b); // R11
    assign hall_change = hall_en && ((hall ^ hall_d) != '0); // R12
    assign start = (slave_mode == timer_pkg::SLV_TRIGGER) ? (enable && ext_edge) // R13
                                                          : (enable && !en_d);
    assign eff_mode = UP_ONLY ? timer_pkg::CNT_UP : cnt_mode; // R2
    assign step = psc_tick || enc_step;

    // Run latch; in one-pulse operation the first update stops the counter.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run <= 1'b0;
        end else if (!enable) begin
            run <= 1'b0;
        end else if (wrap && step && one_pulse) begin
            run <= 1'b0; // R3
        end else if (start) begin
            run <= 1'b1;
        end
    end

    // Prescaler counts clock sources and wraps at its value, dividing by value plus one.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            psc_cnt <= timer_pkg::PSC_RESET;
        end else if (active && clk_src && (slave_mode != timer_pkg::SLV_ENCODER)) begin
            psc_cnt <= (psc_cnt == psc) ? timer_pkg::PSC_RESET : psc_cnt + 1'b1; // R16 R1
        end
    end

    // Next counter value for the selected direction mode.
    always_comb begin
        next_cnt = cnt;
        next_dir = dir_down;
        wrap     = 1'b0;
        if (enc_step) begin
            if (enc_dn) begin
                wrap     = (cnt == '0);
                next_cnt = wrap ? arr : cnt - 1'b1; // R11
            end else begin
                wrap     = (cnt >= arr);
                next_cnt = wrap ? '0 : cnt + 1'b1;
            end
            next_dir = enc_dn;
        end else begin
            case (eff_mode)
                timer_pkg::CNT_DOWN: begin
                    wrap     = (cnt == '0);
                    next_cnt = wrap ? arr : cnt - 1'b1; // R17 R2
                    next_dir = 1'b1;
                end
                timer_pkg::CNT_CENTER: begin
                    if (arr == '0) begin
                        wrap     = 1'b1;
                        next_cnt = '0;
                    end else if (dir_down) begin
                        wrap     = (cnt == '0);
                        next_cnt = wrap ? cnt + 1'b1 : cnt - 1'b1; // R4
                        next_dir = !wrap;
                    end else begin
                        wrap     = (cnt >= arr);
                        next_cnt = wrap ? cnt - 1'b1 : cnt + 1'b1; // R4
                        next_dir = wrap;
                    end
                end
                default: begin
                    wrap     = (cnt >= arr);
                    next_cnt = wrap ? '0 : cnt + 1'b1; // R17 R15
                    next_dir = 1'b0;
                end
            endcase
        end
    end

    // Counter register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt      <= '0;
            dir_down <= 1'b0;
        end else if (step) begin
            cnt      <= next_cnt; // R1
            dir_down <= next_dir;
        end
    end

    // Sticky update flag; a new update wins over a clear in the same cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            update_flag <= 1'b0;
        end else if (step && wrap) begin
            update_flag <= 1'b1; // R17
        end else if (update_clr) begin
            update_flag <= 1'b0;
        end
    end

    // Update drives the link output to sibling timers and, when present, a DMA request.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link_trig_out <= 1'b0;
            dma_req       <= 1'b0;
        end else begin
            link_trig_out <= step && wrap; // R13
            dma_req       <= HAS_DMA && dma_en && ((step && wrap) || (cap_flag != '0)); // R9 R10 R8
        end
    end

    assign count      = cnt;
    assign count_down = dir_down;

    // Channels; the first NUM_COMP carry complementary pairs, channel zero can see the hall sensors.
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        capture_compare_channel #(
            .CNT_W    (CNT_W),
            .HAS_COMP (i < NUM_COMP)
        ) u_ch (
            .clock     (clock),
            .sys_rst   (sys_rst),
            .cnt_step  (step),
            .cnt       (cnt),
            .cmp       (ch_cmp[i*CNT_W +: CNT_W]),
            .mode      (ch_mode[i*3 +: 3]),
            .cap_in    ((i == 0 && hall_en) ? hall_change : ch_in[i]), // R12
            .dead_time (dead_time),
            .out_p     (ch_out[i]), // R7
            .out_n     (ch_out_n[i]),
            .cap_val   (cap_val[i*CNT_W +: CNT_W]),
            .cap_event (cap_flag[i])
        );
    end

    chk_count_hold: assert property (@(posedge clock) disable iff (sys_rst) // R16
        !step |=> cnt == $past(cnt)) else $error("Counter moved without a step.");

    chk_debug_freeze: assert property (@(posedge clock) disable iff (sys_rst) // R14
        (dbg_halt && dbg_freeze) |-> !step) else $error("Counter stepped during debug halt.");

    chk_up_wrap: assert property (@(posedge clock) disable iff (sys_rst) // R17
        (psc_tick && eff_mode == timer_pkg::CNT_UP && cnt >= arr)
        |=> cnt == '0 && update_flag && link_trig_out) else $error("Up wrap missed.");

    chk_down_reload: assert property (@(posedge clock) disable iff (sys_rst) // R2
        (psc_tick && eff_mode == timer_pkg::CNT_DOWN && cnt == '0)
        |=> cnt == $past(arr) && update_flag) else $error("Down reload missed.");

    chk_up_step: assert property (@(posedge clock) disable iff (sys_rst) // R1
        (psc_tick && eff_mode == timer_pkg::CNT_UP && cnt < arr)
        |=> cnt == $past(cnt) + 1'b1) else $error("Up count did not advance by one.");

    chk_gate_hold: assert property (@(posedge clock) disable iff (sys_rst) // R13
        (slave_mode == timer_pkg::SLV_GATED && !link_trig_in) |-> !step)
        else $error("Counter stepped with the gate closed.");

    chk_dma_update: assert property (@(posedge clock) disable iff (sys_rst) // R10
        (HAS_DMA && dma_en && step && wrap) |=> dma_req) else $error("No DMA request on update.");

    chk_dma_none: assert property (@(posedge clock) disable iff (sys_rst) // R9
        !HAS_DMA |-> !dma_req) else $error("DMA request from a variant without DMA.");

    cov_center_turn: cover property (@(posedge clock) disable iff (sys_rst)
        eff_mode == timer_pkg::CNT_CENTER && $rose(dir_down));
    cov_encoder_down: cover property (@(posedge clock) disable iff (sys_rst) enc_step && enc_dn);
    cov_update: cover property (@(posedge clock) disable iff (sys_rst) link_trig_out ##1 update_clr);

endmodule

// >>> timer_far_side.sv
// Far-side model of the timer: encoder wheel, hall sensors and a sibling timer's link.
// Assumes its tasks are called from one bench process aligned to the falling clock edge.
`timescale 1ns/100ps
module timer_far_side (
    input  wire logic       clock,
    output logic            enc_a,
    output logic            enc_b,
    output logic [2:0]      hall,
    output logic            link_trig_in
);
    // Idle levels at time zero; hall starts on a legal one-hot sensor pattern.
    initial begin
        enc_a = 1'b0;
        enc_b = 1'b0;
        hall = 3'h1;
        link_trig_in = 1'b0;
    end

    // Quadrature steps walk the Gray order, four cycles apart, so no two edges merge.
    task automatic enc_move(int n, bit fwd);
        logic [1:0] pos;
        repeat (n) begin
            pos = {enc_a, enc_a ^ enc_b};
            pos = fwd ? pos + 2'h1 : pos - 2'h1;
            @(negedge clock);
            enc_a = pos[1];
            enc_b = pos[1] ^ pos[0];
            repeat (3) @(negedge clock);
        end
    endtask

    // A turning rotor moves the single active sensor one place on.
    task automatic hall_turn();
        @(negedge clock);
        hall = {hall[1:0], hall[2]};
    endtask

    // The sibling timer holds its trigger level, or sends pulses two cycles wide.
    task automatic link_set(bit v);
        @(negedge clock);
        link_trig_in = v;
    endtask

    task automatic link_pulses(int n);
        repeat (n) begin
            link_set(1'b1);
            @(negedge clock);
            link_set(1'b0);
            @(negedge clock);
        end
    endtask
endmodule

// >>> tb_multi_channel_pwm_capture_timer.sv
// Self-checking bench for the capture/compare timer with its default four-channel build.
// Assumes a 100 MHz clock and that all inputs change on the falling edge.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_multi_channel_pwm_capture_timer;
    logic                   clock = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   enable, one_pulse, dbg_halt, dbg_freeze, dma_en, update_clr;
    logic                   hall_en, enc_a, enc_b, link_trig_in;
    logic                   count_down, update_flag, dma_req, link_trig_out;
    logic [2:0]             hall;
    logic [7:0]             dead_time;
    logic [15:0]            psc, arr, count;
    logic [11:0]            ch_mode;
    logic [63:0]            ch_cmp, cap_val;
    logic [3:0]             ch_in, ch_out, ch_out_n, cap_flag;
    timer_pkg::cnt_mode_t   cnt_mode;
    timer_pkg::slave_mode_t slave_mode;
    int                     errors = 0;
    int                     tests_run = 0;
    int                     seed = 23;
    int                     cycles = 0;

    multi_channel_pwm_capture_timer i_dut (.clock(clock), .sys_rst(sys_rst), .enable(enable),
        .one_pulse(one_pulse), .dbg_halt(dbg_halt), .dbg_freeze(dbg_freeze), .psc(psc),
        .arr(arr), .cnt_mode(cnt_mode), .slave_mode(slave_mode), .link_trig_in(link_trig_in),
        .enc_a(enc_a), .enc_b(enc_b), .hall(hall), .hall_en(hall_en), .ch_mode(ch_mode),
        .ch_cmp(ch_cmp), .ch_in(ch_in), .dead_time(dead_time), .dma_en(dma_en),
        .update_clr(update_clr), .ch_out(ch_out), .ch_out_n(ch_out_n), .cap_val(cap_val),
        .cap_flag(cap_flag), .count(count), .count_down(count_down),
        .update_flag(update_flag), .dma_req(dma_req), .link_trig_out(link_trig_out));

    timer_far_side i_far (.clock(clock), .enc_a(enc_a), .enc_b(enc_b), .hall(hall),
        .link_trig_in(link_trig_in));

    // Free-running 100 MHz clock.
    always #5 clock = ~clock;

    task automatic print_verdict();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the 1200 or so cycles the sequence needs at most.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic cyc(int n);
        repeat (n) @(negedge clock);
    endtask

    // Counter value after s steps from reset, up or down, wrapping at the reload value.
    function automatic logic [15:0] exp_count(int s, int a, timer_pkg::cnt_mode_t m);
        int r;
        r = s % (a + 1);
        return (m == timer_pkg::CNT_UP) ? 16'(r) : 16'((a + 1 - r) % (a + 1));
    endfunction

    // High cycles of one PWM period for a compare value; center mode runs 0..a..1.
    function automatic int duty(int c, int a, timer_pkg::cnt_mode_t m);
        int h;
        h = (c > a) ? a + 1 : c;
        if (m == timer_pkg::CNT_CENTER && c > 1) h += (c > a) ? a - 1 : c - 1;
        return h;
    endfunction

    // Reset, load the count setup, then raise enable; the next rising edge samples it.
    task automatic restart(int p, int a, timer_pkg::cnt_mode_t m);
        sys_rst = 1'b1;
        enable = 1'b0;
        psc = 16'(p);
        arr = 16'(a);
        cnt_mode = m;
        cyc(2);
        sys_rst = 1'b0;
        cyc(1);
        enable = 1'b1;
    endtask

    // Steps come every psc+1 cycles; each wrap pulses the link and, if enabled, DMA.
    task automatic run_count(int p, int a, timer_pkg::cnt_mode_t m);
        int s;
        int sp;
        logic w;
        sp = 0;
        restart(p, a, m);
        cyc(1);
        for (int j = 1; j <= 40; j++) begin
            cyc(1);
            s = j / (p + 1);
            w = (s != sp) && (exp_count(s, a, m) == ((m == timer_pkg::CNT_UP) ? 0 : a));
            `CHK(count, exp_count(s, a, m))
            `CHK(link_trig_out, w)
            `CHK(dma_req, w & dma_en)
            sp = s;
        end
        `CHK(update_flag, 1'b1)
    endtask

    // Four PWM channels: random duty, constant low, constant high, and a plain pin.
    task automatic pwm_run(timer_pkg::cnt_mode_t m);
        int a;
        int c3;
        int len;
        logic [15:0] h1, h2, h3, n1, n3, both;
        a = 3 + $unsigned($random(seed)) % 12;
        c3 = $unsigned($random(seed)) % (a + 2);
        len = (m == timer_pkg::CNT_UP) ? a + 1 : 2 * a;
        dead_time = 8'($unsigned($random(seed)) % 4);
        ch_mode = {4{3'b011}};
        ch_cmp = {16'(c3), 16'(a + 1), 16'h0000, 16'($unsigned($random(seed)) % (a + 2))};
        {h1, h2, h3, n1, n3, both} = '0;
        restart(0, a, m);
        cyc(3 * len + 12);
        repeat (4 * len) begin
            cyc(1);
            h1 += ch_out[1];
            h2 += ch_out[2];
            h3 += ch_out[3];
            n1 += ch_out_n[1];
            n3 += ch_out_n[3];
            both += |(ch_out[2:0] & ch_out_n[2:0]);
        end
        `CHK(h3, 16'(4 * duty(c3, a, m)))
        `CHK(h1, 16'h0000)
        `CHK(h2, 16'(4 * len))
        `CHK(n1, 16'(4 * len))
        `CHK(n3, 16'h0000)
        `CHK(both, 16'h0000)
    endtask

    // Waits a few cycles for a capture pulse on channel k and reports whether it came.
    task automatic cap_wait(int k);
        repeat (5) if (cap_flag[k] !== 1'b1) cyc(1);
        `CHK(cap_flag[k], 1'b1)
    endtask

    // Main sequence: one fixed count, random setups in the loops, then corner cases.
    initial begin
        logic [15:0] c;
        {enable, one_pulse, dbg_halt, dbg_freeze, dma_en, update_clr, hall_en} = '0;
        {psc, arr, ch_mode, ch_cmp, ch_in, dead_time} = '0;
        cnt_mode = timer_pkg::CNT_UP;
        slave_mode = timer_pkg::SLV_FREE;
        repeat (10) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        run_count(0, 2, timer_pkg::CNT_UP);
        for (int i = 0; i < 6; i++) begin
            dma_en = $random(seed);
            run_count($unsigned($random(seed)) % 4, 2 + $unsigned($random(seed)) % 8,
                (i % 2) ? timer_pkg::CNT_DOWN : timer_pkg::CNT_UP);
        end
        for (int i = 0; i < 4; i++) pwm_run((i % 2) ? timer_pkg::CNT_CENTER : timer_pkg::CNT_UP);
        // Debug halt freezes the count only while freezing is asked for.
        ch_mode = '0;
        restart(0, 255, timer_pkg::CNT_UP);
        cyc(6);
        {dbg_halt, dbg_freeze} = 2'b11;
        cyc(2);
        c = count;
        cyc(8);
        `CHK(count, c)
        dbg_freeze = 1'b0;
        cyc(4);
        `CHK(count, c + 16'h0004)
        dbg_halt = 1'b0;
        // Capture on channel 1 keeps the count seen at the sampling edge.
        dma_en = 1'b1;
        ch_mode = 12'h008;
        cyc($unsigned($random(seed)) % 20);
        c = count;
        ch_in[1] = 1'b1;
        cap_wait(1);
        `CHK(cap_val[31:16], c)
        cyc(1);
        `CHK(dma_req, 1'b1)
        ch_in[1] = 1'b0;
        // A hall change captures on channel 0.
        ch_mode = 12'h001;
        hall_en = 1'b1;
        i_far.hall_turn();
        cap_wait(0);
        hall_en = 1'b0;
        // Gated: held while the link is low, runs while high.
        slave_mode = timer_pkg::SLV_GATED;
        restart(0, 255, timer_pkg::CNT_UP);
        cyc(8);
        `CHK(count, 16'h0000)
        i_far.link_set(1'b1);
        cyc(8);
        i_far.link_set(1'b0);
        cyc(2);
        c = count;
        cyc(5);
        `CHK(count, c)
        `CHK(c != 16'h0000, 1'b1)
        // External clock: each link pulse is one count.
        slave_mode = timer_pkg::SLV_EXT_CLOCK;
        restart(0, 255, timer_pkg::CNT_UP);
        i_far.link_pulses(5);
        cyc(3);
        `CHK(count, 16'h0005)
        // Encoder: twelve steps forward, five back.
        slave_mode = timer_pkg::SLV_ENCODER;
        restart(0, 65535, timer_pkg::CNT_UP);
        i_far.enc_move(12, 1'b1);
        cyc(3);
        `CHK(count, 16'h000c)
        `CHK(count_down, 1'b0)
        i_far.enc_move(5, 1'b0);
        cyc(3);
        `CHK(count, 16'h0007)
        `CHK(count_down, 1'b1)
        // One pulse stops at the first update; a clear then drops the sticky flag.
        slave_mode = timer_pkg::SLV_FREE;
        one_pulse = 1'b1;
        restart(0, 3, timer_pkg::CNT_UP);
        cyc(14);
        `CHK(count, 16'h0000)
        `CHK(update_flag, 1'b1)
        update_clr = 1'b1;
        cyc(1);
        update_clr = 1'b0;
        cyc(1);
        `CHK(update_flag, 1'b0)
        print_verdict();
    end
endmodule
